// File: load_protection_latch.v
// Fault supervision and latched protection for an electronic load
`timescale 1ns/100ps
`include "load_prot_consts.vh"
module load_protection_latch #(
   parameter        VW            = 16,
   parameter        IW            = 16,
   parameter [15:0] OV_THRESHOLD  = 16'hfa00,
   parameter [31:0] POWER_MAX     = 32'h0100_0000,
   parameter [31:0] OCP_DELAY_RST = `OCP_DELAY_CYC,
   parameter [31:0] OPP_DELAY     = `OPP_DELAY_CYC
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          ce,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire [VW-1:0] meas_voltage,
   input  wire [IW-1:0] meas_current,
   input  wire          over_temp_sense,
   input  wire          reverse_sense,
   input  wire          clamp_sense,
   input  wire          panel_clear,
   input  wire          panel_input_toggle,
   output reg           input_switch_q,
   output reg           power_clamp_q,
   output reg           beep_q,
   output reg           pending_trip_indication,
   output reg  [4:0]    fault_display_q
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg                 ocp_en_q;
   reg [IW-1:0]        ocp_limit_q;
   reg [31:0]          ocp_delay_q;
   reg                 latched_q;
   reg                 overvoltage_flag;
   reg                 overcurrent_flag;
   reg                 overpower_flag;
   reg                 overtemp_flag;
   reg                 reverse_voltage_flag;
   reg                 voltage_fault_summary;
   reg                 protection_summary;
   reg [`ST_WIDTH-1:0] status_prev_q;
   reg [`ST_WIDTH-1:0] event_q;
   reg [`ST_WIDTH-1:0] event_en_q;
   reg [31:0]          power_q;
   reg [15:0]          resist_q;

   wire [`ST_WIDTH-1:0] status_w;
   wire                 access = psel & penable & pready;
   wire                 wr     = access & pwrite;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = hit(a, `OFS_CTRL) | hit(a, `OFS_OCP_LIMIT) | hit(a, `OFS_OCP_DELAY) |
                  hit(a, `OFS_CLEAR) | hit(a, `OFS_STATUS) | hit(a, `OFS_EVENT) |
                  hit(a, `OFS_EVENT_EN) | hit(a, `OFS_POWER) | hit(a, `OFS_RESIST);
      end
   endfunction

   // ----------------------------------------
   // Clear requests and fault conditions
   // ----------------------------------------
   wire clr_req = panel_clear | (wr & hit(paddr, `OFS_CLEAR) & pwdata[`CLEAR_REQ]);
   wire [31:0] v_ext   = {{(32-VW){1'b0}}, meas_voltage};
   wire [31:0] i_ext   = {{(32-IW){1'b0}}, meas_current};
   wire [31:0] power_w = v_ext * i_ext;

   wire ov_now = (v_ext > {16'h0000, OV_THRESHOLD});
   wire oc_now = ocp_en_q & (meas_current > ocp_limit_q);
   wire op_now = clamp_sense | (power_w > POWER_MAX);
   wire ot_now = over_temp_sense;
   wire rv_now = reverse_sense;

   wire oc_expired;
   wire op_expired;

   dur_timer #(
      .W (32)
   ) u_oc_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (oc_now & ~latched_q),
      .clear   (clr_req),
      .limit   (ocp_delay_q),
      .expired (oc_expired)
   );

   dur_timer #(
      .W (32)
   ) u_op_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (op_now & ~latched_q),
      .clear   (1'b0),
      .limit   (OPP_DELAY),
      .expired (op_expired)
   );

   wire trip_ov  = ov_now;
   wire trip_oc  = oc_expired & ~clr_req;
   wire trip_op  = op_expired;
   wire trip_any = trip_ov | trip_oc | trip_op | ot_now | rv_now;
   // Overcurrent excluded: its timer rearms after a clear
   wire cond_any = ov_now | op_now | ot_now | rv_now;
   // Flag released only by a clear once its condition is gone
   wire free_ov  = clr_req & ~ov_now;
   wire free_oc  = clr_req & ~oc_now;
   wire free_op  = clr_req & ~op_now;
   wire free_ot  = clr_req & ~ot_now;
   wire free_rv  = clr_req & ~rv_now;

   // ----------------------------------------
   // Protection latch and fault flags
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_q               <= 1'b0;
         input_switch_q          <= 1'b0;
         beep_q                  <= 1'b0;
         pending_trip_indication <= 1'b0;
         fault_display_q         <= 5'h00;
         overvoltage_flag        <= 1'b0;
         overcurrent_flag        <= 1'b0;
         overpower_flag          <= 1'b0;
         overtemp_flag           <= 1'b0;
         reverse_voltage_flag    <= 1'b0;
         voltage_fault_summary   <= 1'b0;
         protection_summary      <= 1'b0;
      end else if (ce) begin
         beep_q <= trip_any & ~latched_q;
         overvoltage_flag      <= trip_ov | (overvoltage_flag & ~free_ov);
         voltage_fault_summary <= trip_ov | rv_now |
                                  (voltage_fault_summary & ~(free_ov & free_rv));
         overcurrent_flag      <= trip_oc | (overcurrent_flag & ~free_oc);
         overpower_flag        <= trip_op | (overpower_flag & ~free_op);
         overtemp_flag         <= ot_now | (overtemp_flag & ~free_ot);
         reverse_voltage_flag  <= rv_now | (reverse_voltage_flag & ~free_rv);
         protection_summary    <= trip_oc | trip_op | ot_now |
                                  (protection_summary & ~(free_oc & free_op & free_ot));
         pending_trip_indication <= oc_now & ~oc_expired & ~latched_q & ~trip_any;
         fault_display_q <= {trip_ov | overvoltage_flag, trip_oc | overcurrent_flag,
                             trip_op | overpower_flag, ot_now | overtemp_flag,
                             rv_now | reverse_voltage_flag};
         if (trip_any) begin
            latched_q      <= 1'b1;
            input_switch_q <= 1'b0;
         end else if (latched_q) begin
            input_switch_q <= 1'b0;
            if (clr_req) begin
               latched_q <= cond_any;
            end
         end else if (wr && hit(paddr, `OFS_CTRL)) begin
            input_switch_q <= pwdata[`CTRL_INPUT_ON];
         end else if (panel_input_toggle) begin
            input_switch_q <= ~input_switch_q;
         end
      end
   end

   // ----------------------------------------
   // Power clamp and resistance divider
   // ----------------------------------------
   reg [4:0]  div_cnt_q;
   reg [15:0] div_quo_q;
   reg [16:0] div_rem_q;
   reg [15:0] div_den_q;
   wire [16:0] rem_shift = {div_rem_q[15:0], div_quo_q[15]};
   wire        rem_ge    = (rem_shift >= {1'b0, div_den_q});

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_clamp_q <= 1'b0;
         power_q       <= 32'h0000_0000;
         resist_q      <= 16'hffff;
         div_cnt_q     <= 5'h00;
         div_quo_q     <= 16'h0000;
         div_rem_q     <= 17'h0_0000;
         div_den_q     <= 16'h0000;
      end else if (ce) begin
         power_clamp_q <= (power_w > POWER_MAX);
         power_q       <= power_w;
         if (div_cnt_q == 5'h00) begin
            div_quo_q <= v_ext[15:0];
            div_den_q <= i_ext[15:0];
            div_rem_q <= 17'h0_0000;
            div_cnt_q <= 5'h10;
         end else begin
            div_rem_q <= rem_ge ? (rem_shift - {1'b0, div_den_q}) : rem_shift;
            div_quo_q <= {div_quo_q[14:0], rem_ge};
            div_cnt_q <= div_cnt_q - 5'h01;
            if (div_cnt_q == 5'h01) begin
               resist_q <= (div_den_q == 16'h0000) ? 16'hffff :
                           {div_quo_q[14:0], rem_ge};
            end
         end
      end
   end

   // ----------------------------------------
   // Status events
   // ----------------------------------------
   assign status_w = {power_clamp_q, input_switch_q, latched_q, pending_trip_indication,
                      protection_summary, voltage_fault_summary, reverse_voltage_flag,
                      overtemp_flag, overpower_flag, overcurrent_flag, overvoltage_flag};

   wire [`ST_WIDTH-1:0] ev_set = status_w & ~status_prev_q & event_en_q;
   wire [`ST_WIDTH-1:0] ev_clr = (wr && hit(paddr, `OFS_EVENT)) ?
                                 pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   reg [31:0] rdata_d;
   always @* begin
      rdata_d = 32'h0000_0000;
      case (paddr)
         `OFS_CTRL:      rdata_d = {30'h0, ocp_en_q, input_switch_q};
         `OFS_OCP_LIMIT: rdata_d = {{(32-IW){1'b0}}, ocp_limit_q};
         `OFS_OCP_DELAY: rdata_d = ocp_delay_q;
         `OFS_STATUS:    rdata_d = {{(32-`ST_WIDTH){1'b0}}, status_w};
         `OFS_EVENT:     rdata_d = {{(32-`ST_WIDTH){1'b0}}, event_q};
         `OFS_EVENT_EN:  rdata_d = {{(32-`ST_WIDTH){1'b0}}, event_en_q};
         `OFS_POWER:     rdata_d = power_q;
         `OFS_RESIST:    rdata_d = {16'h0000, resist_q};
         default:        rdata_d = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         prdata        <= 32'h0000_0000;
         ocp_en_q      <= 1'b0;
         ocp_limit_q   <= `RST_OCP_LIMIT;
         ocp_delay_q   <= OCP_DELAY_RST;
         status_prev_q <= {`ST_WIDTH{1'b0}};
         event_q       <= {`ST_WIDTH{1'b0}};
         event_en_q    <= `RST_EVENT_EN;
      end else if (ce) begin
         pready        <= psel & ~penable & ~pready;
         pslverr       <= psel & ~penable & ~pready & ~mapped(paddr);
         prdata        <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
         status_prev_q <= status_w;
         event_q       <= (event_q & ~ev_clr) | ev_set;
         if (wr && !latched_q) begin
            if (hit(paddr, `OFS_CTRL)) begin
               ocp_en_q <= pwdata[`CTRL_OCP_EN];
            end
            if (hit(paddr, `OFS_OCP_LIMIT)) begin
               ocp_limit_q <= pwdata[IW-1:0];
            end
            if (hit(paddr, `OFS_OCP_DELAY)) begin
               ocp_delay_q <= pwdata;
            end
         end
         if (wr && hit(paddr, `OFS_EVENT_EN)) begin
            event_en_q <= pwdata[`ST_WIDTH-1:0];
         end
      end
   end
endmodule

// File: load_prot_consts.vh
// Constants for the load protection latch
`ifndef LOAD_PROT_CONSTS_VH
`define LOAD_PROT_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_OCP_LIMIT   8'h04
`define OFS_OCP_DELAY   8'h08
`define OFS_CLEAR       8'h0c
`define OFS_STATUS      8'h10
`define OFS_EVENT       8'h14
`define OFS_EVENT_EN    8'h18
`define OFS_POWER       8'h1c
`define OFS_RESIST      8'h20

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_INPUT_ON   0
`define CTRL_OCP_EN     1
`define CLEAR_REQ       0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_OV           0
`define ST_OC           1
`define ST_OP           2
`define ST_OT           3
`define ST_RV           4
`define ST_VF           5
`define ST_PS           6
`define ST_PT           7
`define ST_LATCHED      8
`define ST_INPUT        9
`define ST_CLAMP        10
`define ST_WIDTH        11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL        2'h0
`define RST_OCP_LIMIT   16'h0fa0
`define RST_EVENT_EN    11'h000

// ----------------------------------------
// Timing: 60 s current protection delay at 20 MHz
// ----------------------------------------
`define CLK_HZ          20000000
`define OCP_DELAY_S     60
`define OCP_DELAY_CYC   (`OCP_DELAY_S * `CLK_HZ)
`define OPP_DELAY_US    1000
`define OPP_DELAY_CYC   (`OPP_DELAY_US * (`CLK_HZ / 1000000))

`endif

// File: dur_timer.v
// Duration timer for a fault excess condition
`timescale 1ns/100ps
module dur_timer #(
   parameter W = 32
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         ce,
   input  wire         run,
   input  wire         clear,
   input  wire [W-1:0] limit,
   output wire         expired
);
   reg [W-1:0] count_q;
   reg [W-1:0] count_d;

   // Restart whenever the excess ends or a clear arrives
   always @* begin
      count_d = count_q;
      if (clear || !run) begin
         count_d = {W{1'b0}};
      end else if (count_q < limit) begin
         count_d = count_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= {W{1'b0}};
      end else if (ce) begin
         count_q <= count_d;
      end
   end

   assign expired = run & (count_q >= limit);
endmodule

// File: load_protection_latch_props.sv
// Checker for the load protection latch ports
`timescale 1ns/100ps
module lpl_checker #(
   parameter [15:0] OV_THRESHOLD = 16'hfa00
) (
   input wire        pclk,
   input wire        presetn,
   input wire        ce,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [15:0] meas_voltage,
   input wire        over_temp_sense,
   input wire        reverse_sense,
   input wire        input_switch_q,
   input wire        beep_q,
   input wire        pending_trip_indication
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ov_cuts_input: assert property (ce && meas_voltage > OV_THRESHOLD |=> !input_switch_q)
      else $error("input left on above voltage threshold");
   chk_ot_cuts_input: assert property (ce && over_temp_sense |=> !input_switch_q)
      else $error("input left on with overtemperature");
   chk_rv_cuts_input: assert property (ce && reverse_sense |=> !input_switch_q)
      else $error("input left on with reverse voltage");
   chk_beep_one_cycle: assert property (beep_q |=> !beep_q)
      else $error("beep longer than one cycle");
   chk_beep_input_off: assert property (beep_q |-> !input_switch_q)
      else $error("beep while input on");
   chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
      else $error("no answer in access cycle");
   chk_ready_in_access: assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready outside access cycle");
   chk_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   cov_beep: cover property (beep_q);
   cov_pending: cover property (pending_trip_indication && input_switch_q);
   cov_slverr: cover property (pslverr);
endmodule
bind load_protection_latch lpl_checker #(.OV_THRESHOLD(OV_THRESHOLD)) i_lpl_checker (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .meas_voltage(meas_voltage), .over_temp_sense(over_temp_sense),
   .reverse_sense(reverse_sense), .input_switch_q(input_switch_q), .beep_q(beep_q),
   .pending_trip_indication(pending_trip_indication));

// File: meas_front_model.sv
// Measurement front end model feeding the latch
`timescale 1ns/100ps
module meas_front_model (
   input  wire        pclk,
   input  wire [15:0] v_set,
   input  wire [15:0] i_set,
   input  wire        ot_set,
   input  wire        rv_set,
   output reg  [15:0] meas_voltage,
   output reg  [15:0] meas_current,
   output reg         over_temp_sense,
   output reg         reverse_sense
);
   // One sample of conversion delay
   always @(posedge pclk) begin
      meas_voltage <= v_set;
      meas_current <= i_set;
      over_temp_sense <= ot_set;
      reverse_sense <= rv_set;
   end
endmodule

// File: tb_load_protection_latch.sv
// Testbench for the load protection latch
`timescale 1ns/100ps
`include "load_prot_consts.vh"
module tb_load_protection_latch;
   typedef struct packed {logic [15:0] v; logic [15:0] i; logic ot; logic rv; logic [31:0] st;} row_t;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pclr = 0, ptog = 0, ot = 0, rv = 0;
   reg ce = 1, hw_clamp = 0, err = 0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, rd;
   reg [15:0] v = 16'h0100, i = 16'h0010;
   wire [31:0] prdata;
   wire pready, pslverr, sw, clamp, beep, pend, ots, rvs;
   wire [15:0] mv, mi;
   wire [4:0] disp;
   integer mismatches = 0, checks = 0, cyc = 0, k;
   row_t rows [4];
   always #25 pclk = ~pclk;
   meas_front_model i_meas_front_model (.pclk(pclk), .v_set(v), .i_set(i), .ot_set(ot), .rv_set(rv),
      .meas_voltage(mv), .meas_current(mi), .over_temp_sense(ots), .reverse_sense(rvs));
   load_protection_latch #(.OCP_DELAY_RST(32'd20), .OPP_DELAY(32'd8)) i_load_protection_latch (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas_voltage(mv), .meas_current(mi), .over_temp_sense(ots), .reverse_sense(rvs),
      .clamp_sense(hw_clamp), .panel_clear(pclr), .panel_input_toggle(ptog), .input_switch_q(sw),
      .power_clamp_q(clamp), .beep_q(beep), .pending_trip_indication(pend), .fault_display_q(disp));
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB transfer: setup, then access until ready
   task apb(input w, input [7:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task waitc(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial begin
      rows[0] = {16'hfa01, 16'h0010, 1'b0, 1'b0, 32'h121};
      rows[1] = {16'h0100, 16'h0010, 1'b1, 1'b0, 32'h148};
      rows[2] = {16'h0100, 16'h0010, 1'b0, 1'b1, 32'h130};
      rows[3] = {16'h1000, 16'h1001, 1'b0, 1'b0, 32'h144};
      waitc(3);
      presetn <= 1;
      apb(0, `OFS_OCP_LIMIT, 0); chk(rd, 32'h0fa0);
      apb(0, `OFS_OCP_DELAY, 0); chk(rd, 32'd20);
      apb(0, 8'h24, 0); chk({err, rd}, {1'b1, 32'h0});
      apb(1, `OFS_EVENT_EN, 32'h008);
      $display("test reset done");
      for (k = 0; k < 4; k = k + 1) begin
         apb(1, `OFS_CTRL, 32'h1);
         v <= rows[k].v; i <= rows[k].i; ot <= rows[k].ot; rv <= rows[k].rv;
         waitc(14);
         chk(disp, {rows[k].st[0], rows[k].st[1], rows[k].st[2], rows[k].st[3], rows[k].st[4]});
         chk(clamp, rows[k].st[2]);
         apb(0, `OFS_STATUS, 0); chk(rd & 32'h3ff, rows[k].st);
         apb(0, `OFS_EVENT, 0); chk(rd, rows[k].st & 32'h8);
         apb(1, `OFS_EVENT, 32'h7ff);
         v <= 16'h0100; i <= 16'h0010; ot <= 0; rv <= 0;
         waitc(3);
         apb(1, `OFS_CLEAR, 32'h1);
         apb(0, `OFS_STATUS, 0); chk(rd & 32'h37f, 32'h0);
         $display("test row %0d done", k);
      end
      v <= 16'd100; i <= 16'd5;
      waitc(40);
      apb(0, `OFS_POWER, 0); chk(rd, 32'd500);
      apb(0, `OFS_RESIST, 0); chk(rd, 32'd20);
      $display("test measure done");
      apb(1, `OFS_CTRL, 32'h3);
      i <= 16'h1000;
      waitc(10);
      chk({pend, sw}, 2'b11);
      apb(1, `OFS_CLEAR, 32'h1);
      waitc(12);
      chk(sw, 1'b1);
      waitc(15);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h37f, 32'h142);
      apb(1, `OFS_CTRL, 32'h3);
      ptog <= 1;
      @(posedge pclk) ptog <= 0;
      apb(0, `OFS_STATUS, 0); chk(rd[9], 1'b0);
      i <= 16'h0010;
      waitc(3);
      apb(1, `OFS_CLEAR, 32'h1);
      apb(1, `OFS_CTRL, 32'h3);
      i <= 16'h1000;
      waitc(10);
      i <= 16'h0010;
      waitc(2);
      i <= 16'h1000;
      waitc(15);
      chk(sw, 1'b1);
      i <= 16'h0010;
      $display("test overcurrent done");
      ot <= 1;
      waitc(4);
      apb(1, `OFS_CLEAR, 32'h1);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h100, 32'h100);
      ot <= 0;
      waitc(3);
      pclr <= 1;
      @(posedge pclk) pclr <= 0;
      waitc(3);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h37f, 32'h0);
      $display("test relatch done");
      hw_clamp <= 1;
      waitc(12);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h144, 32'h144);
      hw_clamp <= 0;
      waitc(2);
      apb(1, `OFS_CLEAR, 32'h1);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h37f, 32'h0);
      $display("test clamp done");
      apb(1, `OFS_CTRL, 32'h1);
      ce <= 0; ot <= 1;
      waitc(5);
      chk(sw, 1'b1);
      ce <= 1;
      waitc(2);
      chk(sw, 1'b0);
      ot <= 0;
      waitc(3);
      pclr <= 1;
      @(posedge pclk) pclr <= 0;
      waitc(3);
      apb(0, `OFS_STATUS, 0); chk(rd & 32'h37f, 32'h0);
      $display("test freeze done");
      give_verdict;
   end
endmodule
